//--- auto_black_level_loop.sv
// automatic black level loop: registers, window timing, line counting
`timescale 1ns/100ps

// Functional notes
// - control mode 00 or 11 turns the loop off; offsets keep software values.
// - while enabled and active, each channel offset is rewritten once per line.
// - window timed from falling edge of shift pulse or input clamp pulse.
// - window starts a position-register count of pixel periods after that edge.
// - mode field 01 selects the shift pulse, 10 selects the clamp pulse.
// - converter output is sampled while the window is open and summed.
// - pixels averaged per line are 4, 8, 16 or 32 by a two-bit field.
// - 10-bit target compared with converter output above its four low bits.
// - after the last pixel, error is target minus average.
// - only error divided by 8, 16, 32 or 64 is added to offset.
// - line field runs loop for 15, 31, 63 lines or without limit.
// - after the selected line count the offsets stop changing.
// - unlimited setting updates every line while the loop is enabled.
// - correction is limited only by offset dac range; values stay inside.
module auto_black_level_loop (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	// register port
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// timing references
	input  wire logic        line_shift_pulse,
	input  wire logic        input_clamp_pulse,
	input  wire logic        start_of_scan,
	// converter outputs
	input  wire logic [15:0] adc_red,
	input  wire logic [15:0] adc_green,
	input  wire logic [15:0] adc_blue,
	// loop outputs
	output logic             black_cal_window,
	output logic             loop_active,
	output logic      [7:0]  offset_red,
	output logic      [7:0]  offset_green,
	output logic      [7:0]  offset_blue
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]                 ctrl;
		logic [7:0]                 pos;
		logic [9:0]                 target;
		logic                       clamp_s1;
		logic                       clamp_s2;
		logic                       clamp_prev;
		logic                       shift_prev;
		black_loop_pkg::win_state_e state;
		logic [7:0]                 dly_cnt;
		logic [4:0]                 win_cnt;
		logic [5:0]                 line_cnt;
		logic                       active;
		logic [7:0]                 rdata;
	} loop_state_s;

	localparam loop_state_s LOOP_RESET = '{
		ctrl:       black_loop_pkg::CTRL_RESET,
		pos:        black_loop_pkg::POS_RESET,
		target:     black_loop_pkg::TGT_RESET,
		clamp_s1:   1'b0,
		clamp_s2:   1'b0,
		clamp_prev: 1'b0,
		shift_prev: 1'b0,
		state:      black_loop_pkg::ST_IDLE,
		dly_cnt:    8'h00,
		win_cnt:    5'h00,
		line_cnt:   6'h00,
		active:     1'b0,
		rdata:      8'h00
	};

	loop_state_s s_reg;
	loop_state_s s_next;

	logic [1:0]  mode_sel;
	logic [1:0]  integ_sel;
	logic [1:0]  pix_sel;
	logic [1:0]  lines_sel;
	logic        loop_en;
	logic        shift_fall;
	logic        clamp_fall;
	logic        ref_fall;
	logic        in_win;
	logic        win_first;
	logic        win_last;
	logic        update_fire;
	logic [2:0]  ofs_wr;
	logic [15:0] adc_ch [3];
	logic [7:0]  ofs_ch [3];

	// ----------------------------------------------------------------
	// control decode
	// ----------------------------------------------------------------
	assign mode_sel  = s_reg.ctrl[black_loop_pkg::MODE_LSB +: 2];
	assign integ_sel = s_reg.ctrl[black_loop_pkg::INTEG_LSB +: 2];
	assign pix_sel   = s_reg.ctrl[black_loop_pkg::PIX_LSB +: 2];
	assign lines_sel = s_reg.ctrl[black_loop_pkg::LINES_LSB +: 2];

	// loop runs only with a valid reference selected
	assign loop_en = (mode_sel == black_loop_pkg::REF_SHIFT) ||
		(mode_sel == black_loop_pkg::REF_CLAMP);

	assign shift_fall = s_reg.shift_prev & ~line_shift_pulse;
	assign clamp_fall = s_reg.clamp_prev & ~s_reg.clamp_s2;
	// reference edge chosen by the mode field
	assign ref_fall = (mode_sel == black_loop_pkg::REF_SHIFT) ? shift_fall :
		(mode_sel == black_loop_pkg::REF_CLAMP) ? clamp_fall : 1'b0;

	assign in_win    = (s_reg.state == black_loop_pkg::ST_WIN);
	assign win_first = in_win && (s_reg.win_cnt == black_loop_pkg::pix_count_m1(pix_sel));
	assign win_last  = in_win && (s_reg.win_cnt == 5'h00);
	// one offset update at the end of each line's window
	assign update_fire = win_last && loop_en && s_reg.active;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next            = s_reg;
		s_next.clamp_s1   = input_clamp_pulse;
		s_next.clamp_s2   = s_reg.clamp_s1;
		s_next.clamp_prev = s_reg.clamp_s2;
		s_next.shift_prev = line_shift_pulse;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				black_loop_pkg::ADDR_CTRL: begin
					s_next.ctrl = reg_wdata;
				end
				black_loop_pkg::ADDR_POS: begin
					s_next.pos = reg_wdata;
				end
				black_loop_pkg::ADDR_TGT_LO: begin
					s_next.target[7:0] = reg_wdata;
				end
				black_loop_pkg::ADDR_TGT_HI: begin
					s_next.target[9:8] = reg_wdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// window sequencer
		case (s_reg.state)
			black_loop_pkg::ST_IDLE: begin
				if (ref_fall && s_reg.active) begin
					s_next.state   = black_loop_pkg::ST_WAIT;
					s_next.dly_cnt = s_reg.pos;
				end
			end
			black_loop_pkg::ST_WAIT: begin
				if (s_reg.dly_cnt == 8'h00) begin
					s_next.state   = black_loop_pkg::ST_WIN;
					s_next.win_cnt = black_loop_pkg::pix_count_m1(pix_sel);
				end else begin
					s_next.dly_cnt = s_reg.dly_cnt - 8'h01;
				end
			end
			black_loop_pkg::ST_WIN: begin
				if (s_reg.win_cnt == 5'h00) begin
					s_next.state = black_loop_pkg::ST_IDLE;
				end else begin
					s_next.win_cnt = s_reg.win_cnt - 5'h01;
				end
			end
			default: begin
				s_next.state = black_loop_pkg::ST_IDLE;
			end
		endcase

		// line counting after start of scan
		if (update_fire) begin
			s_next.line_cnt = s_reg.line_cnt + 6'h01;
			if (lines_sel != black_loop_pkg::LINES_UNLIMITED &&
				s_next.line_cnt == black_loop_pkg::line_limit(lines_sel)) begin
				s_next.active = 1'b0;
			end
		end
		if (start_of_scan) begin
			s_next.line_cnt = 6'h00;
			s_next.active   = 1'b1;
		end

		// read data
		case (reg_addr)
			black_loop_pkg::ADDR_CTRL:       s_next.rdata = s_reg.ctrl;
			black_loop_pkg::ADDR_POS:        s_next.rdata = s_reg.pos;
			black_loop_pkg::ADDR_TGT_LO:     s_next.rdata = s_reg.target[7:0];
			black_loop_pkg::ADDR_TGT_HI:     s_next.rdata = {6'h00, s_reg.target[9:8]};
			black_loop_pkg::ADDR_OFS0:       s_next.rdata = ofs_ch[0];
			black_loop_pkg::ADDR_OFS0 + 8'h01: s_next.rdata = ofs_ch[1];
			black_loop_pkg::ADDR_OFS0 + 8'h02: s_next.rdata = ofs_ch[2];
			black_loop_pkg::ADDR_STATUS:     s_next.rdata = {s_reg.active, in_win, s_reg.line_cnt};
			default:                         s_next.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= LOOP_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// channels
	// ----------------------------------------------------------------
	assign adc_ch[0] = adc_red;
	assign adc_ch[1] = adc_green;
	assign adc_ch[2] = adc_blue;

	for (genvar i = 0; i < black_loop_pkg::N_CH; i++) begin : g_ch
		assign ofs_wr[i] = reg_wr && (reg_addr == black_loop_pkg::ADDR_OFS0 + 8'(i));
		black_channel u_ch (
			.clk_sys     (clk_sys),
			.resetn      (resetn),
			.adc_data    (adc_ch[i]),
			.win_sample  (in_win),
			.win_first   (win_first),
			.update_fire (update_fire),
			.pix_sel     (pix_sel),
			.integ_sel   (integ_sel),
			.target      (s_reg.target),
			.man_wr      (ofs_wr[i]),
			.man_data    (reg_wdata),
			.offset      (ofs_ch[i])
		);
	end

	assign reg_rdata        = s_reg.rdata;
	assign black_cal_window = in_win;
	assign loop_active      = s_reg.active;
	assign offset_red       = ofs_ch[0];
	assign offset_green     = ofs_ch[1];
	assign offset_blue      = ofs_ch[2];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [8:0] edge_age;

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			edge_age <= 9'h000;
		end else if (s_reg.state == black_loop_pkg::ST_IDLE && s_next.state == black_loop_pkg::ST_WAIT) begin
			edge_age <= 9'h000;
		end else if (edge_age != 9'h1FF) begin
			edge_age <= edge_age + 9'h001;
		end
	end

	AST_HOLD_OFF: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!update_fire && ofs_wr == 3'h0)
		|=> $stable(ofs_ch[0]) && $stable(ofs_ch[1]) && $stable(ofs_ch[2]))
		else $error("offset changed without update or write");

	AST_LINE_STEP: assert property (@(posedge clk_sys) disable iff (!resetn)
		(update_fire && !start_of_scan) |=> s_reg.line_cnt == 6'($past(s_reg.line_cnt) + 6'h01))
		else $error("line count not advanced by update");

	AST_REF_EDGE: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_reg.state == black_loop_pkg::ST_IDLE ##1 s_reg.state == black_loop_pkg::ST_WAIT)
		|-> $past(ref_fall))
		else $error("window timing started without reference edge");

	AST_WIN_POS: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(black_cal_window) && $stable(s_reg.pos)) |-> edge_age == {1'b0, s_reg.pos} + 9'h001)
		else $error("window start not at programmed position");

	AST_NO_REF: assert property (@(posedge clk_sys) disable iff (!resetn)
		(s_reg.state == black_loop_pkg::ST_IDLE && !loop_en) |=> s_reg.state != black_loop_pkg::ST_WAIT)
		else $error("window armed with invalid mode");

	AST_WIN_4: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(black_cal_window) && pix_sel == 2'h0) |-> black_cal_window[*4] ##1 !black_cal_window)
		else $error("window not four pixels long");

	AST_WIN_8: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(black_cal_window) && pix_sel == 2'h1) |-> black_cal_window[*8] ##1 !black_cal_window)
		else $error("window not eight pixels long");

	AST_LINE_STOP: assert property (@(posedge clk_sys) disable iff (!resetn)
		(update_fire && !start_of_scan && lines_sel == 2'h0 && s_reg.line_cnt == 6'h0E)
		|=> !loop_active ##1 !update_fire)
		else $error("loop still active after line limit");

	AST_UNLIMITED: assert property (@(posedge clk_sys) disable iff (!resetn)
		(update_fire && lines_sel == black_loop_pkg::LINES_UNLIMITED)
		|=> loop_active)
		else $error("unlimited loop stopped after an update");

	AST_SOS_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
		start_of_scan |=> (s_reg.line_cnt == 6'h00) && loop_active)
		else $error("start of scan did not restart line count");

endmodule : auto_black_level_loop

//--- auto_black_level_loop_test.sv
// self-checking bench for the automatic black level loop
`timescale 1ns/100ps

module auto_black_level_loop_test;
	logic             clk_sys   = 1'b0;
	logic             resetn    = 1'b0;
	logic             reg_wr    = 1'b0;
	logic [7:0]       reg_addr  = 8'h00;
	logic [7:0]       reg_wdata = 8'h00;
	logic [7:0]       reg_rdata;
	logic             shift_p;
	logic             clamp_p;
	logic             start_of_scan = 1'b0;
	logic             go = 1'b0;
	logic [2:0][15:0] lvl = '0;
	logic [2:0][15:0] adc;
	logic             win;
	logic             loop_active;
	logic [2:0][7:0]  ofs;
	int               n_mismatch = 0;
	int               samples_checked = 0;
	int               seed = 74;
	int               cycles = 0;
	// ----------------------------------------------------------------
	// reference model state
	// ----------------------------------------------------------------
	int               m_ofs [3] = '{0, 0, 0};
	int               m_tgt, m_pos, m_cnt, m_mask, m_or;
	logic [7:0]       m_ctrl;
	bit               m_act = 1'b0;

	auto_black_level_loop dut_u (
		.clk_sys(clk_sys), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_shift_pulse(shift_p),
		.input_clamp_pulse(clamp_p), .start_of_scan(start_of_scan), .adc_red(adc[0]),
		.adc_green(adc[1]), .adc_blue(adc[2]), .black_cal_window(win),
		.loop_active(loop_active), .offset_red(ofs[0]), .offset_green(ofs[1]),
		.offset_blue(ofs[2])
	);

	black_sensor_model sensor_u (
		.clk_sys(clk_sys), .go(go), .lvl(lvl), .line_shift_pulse(shift_p),
		.input_clamp_pulse(clamp_p), .adc(adc)
	);

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		@(posedge clk_sys);
		#1 d = reg_rdata;
	endtask : rd

	task automatic setup(input logic [7:0] ctrl, input int pos, input int tgt);
		m_ctrl = ctrl;
		m_pos  = pos;
		m_tgt  = tgt;
		wr(black_loop_pkg::ADDR_CTRL, ctrl);
		wr(black_loop_pkg::ADDR_POS, 8'(pos));
		wr(black_loop_pkg::ADDR_TGT_LO, 8'(tgt));
		wr(black_loop_pkg::ADDR_TGT_HI, 8'(tgt >> 8));
		@(posedge clk_sys);
		start_of_scan <= 1'b1;
		@(posedge clk_sys);
		start_of_scan <= 1'b0;
		m_cnt = 0;
		m_act = 1'b1;
	endtask : setup

	task automatic run_line;
		int         rise, width, avg, upd;
		int         nl [3];
		logic [7:0] st;
		rise  = 0;
		width = 0;
		upd   = (m_ctrl[1:0] == 2'h1 || m_ctrl[1:0] == 2'h2) && m_act;
		@(posedge clk_sys);
		for (int c = 0; c < 3; c++) begin
			nl[c] = ($random(seed) & m_mask) | m_or;
			lvl[c] <= 16'(nl[c]);
		end
		go <= 1'b1;
		for (int i = 1; i < 136; i++) begin
			@(posedge clk_sys);
			go <= 1'b0;
			#1;
			if (win === 1'b1) begin
				if (width == 0)
					rise = i;
				width++;
			end
		end
		if (upd) begin
			// shift edge is seen at once, the clamp edge only after its two sync stages
			check("window start", 16'(rise), 16'(m_pos + (m_ctrl[1:0] == 2'h1 ? 9 : 8)));
			check("window length", 16'(width), 16'(4 << m_ctrl[5:4]));
			for (int c = 0; c < 3; c++) begin
				avg = nl[c] + 1;
				m_ofs[c] += (m_tgt - (avg >>> 4)) >>> (3 + m_ctrl[3:2]);
				m_ofs[c] = m_ofs[c] > 127 ? 127 : m_ofs[c] < -128 ? -128 : m_ofs[c];
			end
			m_cnt++;
			m_act = m_ctrl[7:6] == 2'h3 || m_cnt < (16 << m_ctrl[7:6]) - 1;
		end else
			check("window idle", 16'(width), 16'h0000);
		for (int c = 0; c < 3; c++)
			check("offset", {8'h00, ofs[c]}, {8'h00, 8'(m_ofs[c])});
		check("active", {15'h0000, loop_active}, {15'h0000, m_act});
		if (m_ctrl[7:6] != 2'h3) begin
			rd(black_loop_pkg::ADDR_STATUS, st);
			check("status", {8'h00, st}, {8'h00, m_act, 1'b0, 6'(m_cnt)});
		end
	endtask : run_line

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int k = 8; k < 16; k++) begin
			rd(8'(k), d);
			check("reset value", {8'h00, d}, 16'h0000);
		end
		wr(8'h20, 8'hFF);
		rd(8'h20, d);
		check("unmapped", {8'h00, d}, 16'h0000);
		// manual offsets stay while the loop is off, in both off codes
		m_mask = 16'h3FFF;
		m_or   = 0;
		for (int c = 0; c < 3; c++) begin
			m_ofs[c] = $signed(8'($random(seed)));
			wr(8'(black_loop_pkg::ADDR_OFS0 + c), 8'(m_ofs[c]));
			rd(8'(black_loop_pkg::ADDR_OFS0 + c), d);
			check("offset readback", {8'h00, d}, {8'h00, 8'(m_ofs[c])});
		end
		setup(8'h03, 5, 100);
		run_line();
		setup(8'h00, 5, 100);
		run_line();
		// every line, pixel and divide setting, both references
		for (int k = 0; k < 4; k++) begin
			setup({2'(k), 2'(k), 2'(3 - k), k[0] ? 2'h1 : 2'h2},
				$random(seed) & 31, $random(seed) & 1023);
			repeat (k == 3 ? 64 : (16 << k) + 1) run_line();
		end
		wr(black_loop_pkg::ADDR_CTRL, 8'hC0);
		m_ctrl = 8'hC0;
		run_line();
		// offsets clip at both ends instead of wrapping
		m_mask = 0;
		setup(8'h01, 0, 1023);
		repeat (3) run_line();
		m_or = 16'hFFF0;
		setup(8'h01, 0, 0);
		repeat (2) run_line();
		end_of_test();
	end
endmodule : auto_black_level_loop_test

//--- black_channel.sv
// one channel: black pixel averaging and offset integration
`timescale 1ns/100ps

module black_channel (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     resetn,
	// converter sample
	input  wire logic [15:0]              adc_data,
	// window control
	input  wire logic                     win_sample,
	input  wire logic                     win_first,
	input  wire logic                     update_fire,
	input  wire logic [1:0]               pix_sel,
	input  wire logic [1:0]               integ_sel,
	input  wire logic [9:0]               target,
	// manual offset write
	input  wire logic                     man_wr,
	input  wire logic [7:0]               man_data,
	// offset dac code
	output logic      [7:0]               offset
);

	typedef struct packed {
		logic [20:0] sum;
		logic [7:0]  offset;
	} chan_state_s;

	localparam chan_state_s CHAN_RESET = '{sum: 21'h000000,
		offset: black_loop_pkg::OFS_RESET};

	chan_state_s        s_reg;
	chan_state_s        s_next;
	logic [20:0]        sum_total;
	logic [15:0]        avg;
	logic signed [12:0] err;
	logic signed [12:0] step;
	logic signed [13:0] wide;

	always_comb begin
		s_next    = s_reg;
		// first sample restarts the sum, later ones accumulate
		sum_total = win_first ? 21'(adc_data) : s_reg.sum + 21'(adc_data);
		// average by shifting the sum by log2 of the count
		avg  = 16'(sum_total >> black_loop_pkg::pix_shift(pix_sel));
		// target minus average on the coarse scale
		err  = $signed({3'h0, target}) - $signed({1'b0, avg[15:4]});
		step = err >>> black_loop_pkg::integ_shift(integ_sel);
		wide = $signed({{6{s_reg.offset[7]}}, s_reg.offset}) + $signed({step[12], step});
		if (win_sample) begin
			s_next.sum = sum_total;
		end
		if (update_fire) begin
			// clip to the dac range instead of wrapping
			if (wide > black_loop_pkg::SAT_HI) begin
				s_next.offset = black_loop_pkg::OFS_MAX;
			end else if (wide < black_loop_pkg::SAT_LO) begin
				s_next.offset = black_loop_pkg::OFS_MIN;
			end else begin
				s_next.offset = wide[7:0];
			end
		end
		if (man_wr) begin
			s_next.offset = man_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			s_reg <= CHAN_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign offset = s_reg.offset;

	AST_STEP_UP: assert property (@(posedge clk_sys) disable iff (!resetn)
		(update_fire && !man_wr && step > 13'sh0000 && $signed(s_reg.offset) != black_loop_pkg::OFS_MAX)
		|=> $signed(s_reg.offset) > $signed($past(s_reg.offset)))
		else $error("offset did not rise on positive step");

	AST_SAT_HIGH: assert property (@(posedge clk_sys) disable iff (!resetn)
		(update_fire && !man_wr && wide > black_loop_pkg::SAT_HI)
		|=> $signed(s_reg.offset) == black_loop_pkg::OFS_MAX)
		else $error("offset not clipped at top");

endmodule : black_channel

//--- black_loop_pkg.sv
// constants, field layout and helpers shared by the black level loop
package black_loop_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_POS    = 8'h09;
	localparam logic [7:0] ADDR_TGT_LO = 8'h0A;
	localparam logic [7:0] ADDR_TGT_HI = 8'h0B;
	localparam logic [7:0] ADDR_OFS0   = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h0F;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] POS_RESET  = 8'h00;
	localparam logic [9:0] TGT_RESET  = 10'h000;
	localparam logic [7:0] OFS_RESET  = 8'h00;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int MODE_LSB  = 0;
	localparam int INTEG_LSB = 2;
	localparam int PIX_LSB   = 4;
	localparam int LINES_LSB = 6;

	localparam logic [1:0] REF_SHIFT       = 2'h1;
	localparam logic [1:0] REF_CLAMP       = 2'h2;
	localparam logic [1:0] LINES_UNLIMITED = 2'h3;

	// ----------------------------------------------------------------
	// widths and offset limits
	// ----------------------------------------------------------------
	localparam int N_CH  = 3;
	localparam int ADC_W = 16;
	localparam int SUM_W = 21;
	localparam int OFS_W = 8;

	localparam logic signed [13:0] SAT_HI = 14'sh007F;
	localparam logic signed [13:0] SAT_LO = 14'sh3F80;
	localparam logic signed [7:0]  OFS_MAX = 8'sh7F;
	localparam logic signed [7:0]  OFS_MIN = 8'sh80;

	// ----------------------------------------------------------------
	// window sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_WIN  = 2'b10
	} win_state_e;

	// ----------------------------------------------------------------
	// decoders
	// ----------------------------------------------------------------
	function automatic logic [2:0] pix_shift(input logic [1:0] sel);
		pix_shift = 3'h2 + {1'b0, sel};
	endfunction : pix_shift

	function automatic logic [4:0] pix_count_m1(input logic [1:0] sel);
		pix_count_m1 = 5'((6'h04 << sel) - 6'h01);
	endfunction : pix_count_m1

	function automatic logic [2:0] integ_shift(input logic [1:0] sel);
		integ_shift = 3'h3 + {1'b0, sel};
	endfunction : integ_shift

	function automatic logic [5:0] line_limit(input logic [1:0] sel);
		line_limit = 6'((7'h10 << sel) - 7'h01);
	endfunction : line_limit

endpackage : black_loop_pkg

//--- black_sensor_model.sv
// sensor timing and optical black pixel model facing the black level loop
`timescale 1ns/100ps

module black_sensor_model (
	// clock
	input  wire logic             clk_sys,
	// line request and black level of each channel
	input  wire logic             go,
	input  wire logic [2:0][15:0] lvl,
	// sensor side
	output logic                  line_shift_pulse,
	output logic                  input_clamp_pulse,
	output logic      [2:0][15:0] adc
);
	// ----------------------------------------------------------------
	// line sequencer
	// ----------------------------------------------------------------
	logic [7:0]  cnt_reg  = 8'h00;
	logic [15:0] junk_reg = 16'h5A3C;
	logic        black;

	always @(posedge clk_sys) begin
		cnt_reg  <= go ? 8'h01 : (cnt_reg != 8'h00 && cnt_reg < 8'h82) ? cnt_reg + 8'h01 : 8'h00;
		junk_reg <= ~junk_reg ^ {8'h00, cnt_reg};
	end

	// clamp ends before the black stretch, so no window can overlap it
	assign input_clamp_pulse = cnt_reg >= 8'h01 && cnt_reg <= 8'h03;
	assign line_shift_pulse  = cnt_reg >= 8'h04 && cnt_reg <= 8'h06;
	// black stretch alternates +0/+2, so any even count averages to level+1
	assign black             = cnt_reg >= 8'h04 && cnt_reg < 8'h64;

	always_comb begin
		for (int c = 0; c < 3; c++)
			adc[c] = black ? lvl[c] + {14'h0000, cnt_reg[0], 1'b0} : junk_reg;
	end
endmodule : black_sensor_model
